// [hdl/rts_pkg.sv]
// Constants, types and lookup functions for the retimer register select and reset block
// Operation
// - Shared 0x04 bit 6 restores shared defaults
// - Shared 0x01 reads revision and variant
// - Select values pick shared, A, B, broadcast
// - Select bit 3 with bit 2 set writes both channels
// - Channel reads follow select bits 1:0
// - Select bit 2 chooses channel or shared decode
// - Address 0xFF always hits shared select register
// - Channel 0x00 bit 2 restores channel defaults
// - Both 0x0A bits 3:2 hold recovery reset
// - Clearing override restarts lock and adaptation
// - Rate/subrate in 0x2F[7:4], default 0110
// - Rate 00 divide ratio enables per table
// - Rates 01-11 divide ratio enables per table
// - Lock search tries divide 8 toward 1
// - Group base rates 9.8304 and 12.288 Gbps
package rts_pkg;

	// ==========================================================
	// Register addresses
	localparam logic [7:0] ADDR_REVISION   = 8'h01;  // shared, read-only
	localparam logic [7:0] ADDR_SH_RESET   = 8'h04;  // shared soft reset
	localparam logic [7:0] ADDR_SELECT     = 8'hFF;  // register set select
	localparam logic [7:0] ADDR_CH_RESET   = 8'h00;  // channel soft reset
	localparam logic [7:0] ADDR_OVERRIDE   = 8'h0A;  // recovery reset override
	localparam logic [7:0] ADDR_DIVIDE     = 8'h2F;  // rate / subrate
	localparam logic [7:0] ADDR_ADAPT      = 8'h31;  // adaptation mode
	localparam logic [7:0] ADDR_FCOUNT_0   = 8'h60;  // frequency count bytes
	localparam logic [7:0] ADDR_FCOUNT_1   = 8'h61;
	localparam logic [7:0] ADDR_FCOUNT_2   = 8'h62;
	localparam logic [7:0] ADDR_FCOUNT_3   = 8'h63;
	localparam logic [7:0] ADDR_FCOUNT_4   = 8'h64;

	// ==========================================================
	// Field positions
	localparam int SH_RESET_BIT = 6;  // shared soft reset
	localparam int CH_RESET_BIT = 2;  // channel soft reset
	localparam int OVR_LO_BIT   = 2;  // override pair, low bit
	localparam int OVR_HI_BIT   = 3;  // override pair, high bit
	localparam int RSUB_MSB     = 7;  // rate[1:0], subrate[1:0]
	localparam int RSUB_LSB     = 4;
	localparam int ADAPT_MSB    = 6;  // adaptation mode field
	localparam int ADAPT_LSB    = 5;
	localparam int SEL_BCAST    = 3;  // broadcast writes
	localparam int SEL_CHAN     = 2;  // channel set enable

	// ==========================================================
	// Sizes and reset values
	localparam int         SH_WORDS     = 8;      // shared bytes held
	localparam int         CH_WORDS     = 128;    // channel bytes held
	localparam logic [7:0] SELECT_RST   = 8'h00;
	localparam logic [7:0] SHARED_RST   = 8'h00;
	localparam logic [7:0] DIVIDE_RST   = 8'h60;  // rate 01, subrate 10
	localparam logic [7:0] FCOUNT_0_RST = 8'h26;
	localparam logic [7:0] FCOUNT_1_RST = 8'hB1;
	localparam logic [7:0] FCOUNT_2_RST = 8'h70;
	localparam logic [7:0] FCOUNT_3_RST = 8'hBD;
	localparam logic [7:0] FCOUNT_4_RST = 8'hFF;
	localparam logic [3:0] REVISION_ID  = 4'h1;   // arbitrary value
	localparam logic [3:0] VARIANT_ID   = 4'h5;   // arbitrary value

	// Oscillator base rates in kbps, informational for the search
	localparam int BASE_G0_KBPS = 9830400;
	localparam int BASE_G1_KBPS = 12288000;

	// ==========================================================
	// Timing: dwell on each trial divide ratio
	localparam int                CLK_PERIOD_NS = 25;
	localparam int                TRY_TIME_NS   = 1000;
	localparam int                TRY_CNT_W     = 6;
	localparam logic [TRY_CNT_W-1:0] TRY_CYCLES =
		TRY_CNT_W'(TRY_TIME_NS / CLK_PERIOD_NS);

	// Recovery machine states
	typedef enum logic [2:0] {
		CDR_HELD, CDR_WAIT_SIGNAL, CDR_SEARCH, CDR_ADAPT, CDR_LOCKED
	} rts_cdr_e;

	// Divide enables: [7:4] group 1, [3:0] group 0; bit 3=/8 .. bit 0=/1
	function automatic logic [7:0] rts_ratio_enable(input logic [3:0] rs);
		unique case (rs)
			4'h0:                 return 8'h18;
			4'h1:                 return 8'h17;
			4'h2, 4'h3:           return 8'h77;
			4'h4:                 return 8'h66;
			4'h5:                 return 8'h55;
			4'h6:                 return 8'hFF;
			4'h7, 4'h8, 4'h9:     return 8'h11;
			4'hA:                 return 8'h22;
			4'hB:                 return 8'h66;
			4'hC, 4'hD, 4'hE:     return 8'h11;
			default:              return 8'h18;
		endcase
	endfunction

	// Factory default of one channel byte
	function automatic logic [7:0] rts_ch_default(input logic [6:0] a);
		unique case ({1'b0, a})
			ADDR_DIVIDE:   return DIVIDE_RST;
			ADDR_FCOUNT_0: return FCOUNT_0_RST;
			ADDR_FCOUNT_1: return FCOUNT_1_RST;
			ADDR_FCOUNT_2: return FCOUNT_2_RST;
			ADDR_FCOUNT_3: return FCOUNT_3_RST;
			ADDR_FCOUNT_4: return FCOUNT_4_RST;
			default:       return 8'h00;
		endcase
	endfunction

endpackage : rts_pkg

// [hdl/rts_select_reset.sv]
// Register set steering, soft resets and per-channel recovery control
module rts_select_reset
	import rts_pkg::*;
(
	// Clock, reset, enable
	input  wire logic             clock,
	input  wire logic             srst,
	input  wire logic             ce,
	// Management register port (from the two-wire bus front end)
	input  wire logic             mgmt_req,
	input  wire logic             mgmt_we,
	input  wire logic [7:0]       mgmt_addr,
	input  wire logic [7:0]       mgmt_wdata,
	output logic      [7:0]       mgmt_rdata,
	output logic                  mgmt_ack,
	// Per-channel analog status pins, asynchronous
	input  wire logic [1:0]       signal_detect,
	input  wire logic [1:0]       phase_lock,
	// Per-channel recovery control
	output logic      [1:0]       cdr_held,
	output logic      [1:0]       cdr_locked,
	output logic      [1:0]       adapt_start,
	output logic [1:0][1:0]       adapt_mode,
	output logic      [1:0]       trial_group,
	output logic [1:0][3:0]       trial_divide
);

	// ==========================================================
	// Shared register set and decode
	logic [7:0] sel_q;                  // register set select
	logic [7:0] sh_q [SH_WORDS];        // shared bytes 0x00..0x07
	logic [7:0] mgmt_rdata_q;           // read data register
	logic       mgmt_ack_q;             // answer strobe
	logic       wr_any;                 // write taken this cycle
	logic       rd_any;                 // read taken this cycle
	logic       wr_select;              // write to select register
	logic       wr_shared;              // write into shared set
	logic       sh_reset;               // shared restore request
	logic [1:0] wr_ch;                  // write into each channel set
	logic [7:0] ch_rd [2];              // channel read data

	assign wr_any    = ce & mgmt_req & mgmt_we;
	assign rd_any    = ce & mgmt_req & ~mgmt_we;
	assign wr_select = wr_any & (mgmt_addr == ADDR_SELECT);
	assign wr_shared = wr_any & ~wr_select & ~sel_q[SEL_CHAN];
	assign sh_reset  = wr_shared & (mgmt_addr == ADDR_SH_RESET)
		& mgmt_wdata[SH_RESET_BIT];

	// Channel write steering: broadcast reaches both, else the coded channel
	always_comb begin
		for (int c = 0; c < 2; c++) begin
			wr_ch[c] = wr_any & ~wr_select & sel_q[SEL_CHAN]
				& (sel_q[SEL_BCAST] | (sel_q[1:0] == 2'(c)));
		end
	end

	// Select register; whole byte taken on every write
	always_ff @(posedge clock) begin
		if (srst) begin
			sel_q <= SELECT_RST;
		end else if (sh_reset) begin
			sel_q <= SELECT_RST;
		end else if (wr_select) begin
			sel_q <= mgmt_wdata;
		end
	end

	// Shared bytes; restore happens on the write edge itself
	always_ff @(posedge clock) begin
		if (srst || sh_reset) begin
			for (int k = 0; k < SH_WORDS; k++) begin
				sh_q[k] <= SHARED_RST;
			end
		end else if (wr_shared && mgmt_addr < 8'(SH_WORDS)
				&& mgmt_addr != ADDR_REVISION) begin
			sh_q[mgmt_addr[2:0]] <= mgmt_wdata;
		end
	end

	// Read path; channel reads ignore the broadcast bit
	always_ff @(posedge clock) begin
		if (srst) begin
			mgmt_rdata_q <= 8'h00;
		end else if (rd_any) begin
			if (mgmt_addr == ADDR_SELECT) begin
				mgmt_rdata_q <= sel_q;
			end else if (!sel_q[SEL_CHAN]) begin
				if (mgmt_addr == ADDR_REVISION) begin
					mgmt_rdata_q <= {REVISION_ID, VARIANT_ID};
				end else if (mgmt_addr < 8'(SH_WORDS)) begin
					mgmt_rdata_q <= sh_q[mgmt_addr[2:0]];
				end else begin
					mgmt_rdata_q <= 8'h00;                                    // unheld shared byte
				end
			end else if (!sel_q[1]) begin
				mgmt_rdata_q <= ch_rd[sel_q[0]];
			end else begin
				mgmt_rdata_q <= 8'h00;                                        // no channel 2 or 3
			end
		end
	end

	// Answer one cycle after each taken request
	always_ff @(posedge clock) begin
		if (srst) begin
			mgmt_ack_q <= 1'b0;
		end else if (ce) begin
			mgmt_ack_q <= mgmt_req;
		end
	end

	assign mgmt_rdata = mgmt_rdata_q;
	assign mgmt_ack   = mgmt_ack_q;

	// ==========================================================
	// Per-channel register set and recovery machine
	for (genvar c = 0; c < 2; c++) begin : g_ch
		logic [7:0]           mem_q [CH_WORDS];  // channel bytes 0x00..0x7F
		logic                 ch_reset;          // channel restore request
		logic                 override;          // both override bits set
		logic [7:0]           ratio_en;          // enabled trial slots
		logic                 sig_meta_q;        // signal detect, stage 1
		logic                 sig_q;             // signal detect, stage 2
		logic                 lock_meta_q;       // phase lock, stage 1
		logic                 lock_q;            // phase lock, stage 2
		rts_cdr_e             state_q;           // recovery state
		logic [2:0]           slot_q;            // trial slot index
		logic [TRY_CNT_W-1:0] dwell_q;           // cycles on this slot
		logic                 slot_on;           // current slot enabled

		assign ch_reset = wr_ch[c] & (mgmt_addr == ADDR_CH_RESET)
			& mgmt_wdata[CH_RESET_BIT];
		assign override = mem_q[ADDR_OVERRIDE[6:0]][OVR_HI_BIT]
			& mem_q[ADDR_OVERRIDE[6:0]][OVR_LO_BIT];
		assign ratio_en = rts_ratio_enable(
			mem_q[ADDR_DIVIDE[6:0]][RSUB_MSB:RSUB_LSB]);
		// Slot order: /8 g0, /8 g1, /4 g0, /4 g1 ... /1 g1, base rates per group
		assign slot_on  = ratio_en[{slot_q[0], ~slot_q[2:1]}];
		assign ch_rd[c] = mgmt_addr[7] ? 8'h00 : mem_q[mgmt_addr[6:0]];

		// Channel bytes; frequency counts are host-owned after reset
		always_ff @(posedge clock) begin
			if (srst || ch_reset) begin
				for (int k = 0; k < CH_WORDS; k++) begin
					mem_q[k] <= rts_ch_default(7'(k));
				end
			end else if (wr_ch[c] && !mgmt_addr[7]) begin
				mem_q[mgmt_addr[6:0]] <= mgmt_wdata;
			end
		end

		// Two-stage synchronisers for analog status
		always_ff @(posedge clock) begin
			if (srst) begin
				sig_meta_q  <= 1'b0;
				sig_q       <= 1'b0;
				lock_meta_q <= 1'b0;
				lock_q      <= 1'b0;
			end else if (ce) begin
				sig_meta_q  <= signal_detect[c];
				sig_q       <= sig_meta_q;
				lock_meta_q <= phase_lock[c];
				lock_q      <= lock_meta_q;
			end
		end

		// Recovery machine; override wins over every state
		always_ff @(posedge clock) begin
			if (srst) begin
				state_q <= CDR_WAIT_SIGNAL;
				slot_q  <= 3'h0;
				dwell_q <= '0;
			end else if (ce) begin
				if (override) begin
					state_q <= CDR_HELD;
					slot_q  <= 3'h0;
					dwell_q <= '0;
				end else begin
					unique case (state_q)
						CDR_HELD: begin
							state_q <= CDR_WAIT_SIGNAL;
						end
						CDR_WAIT_SIGNAL: begin
							if (sig_q) begin
								state_q <= CDR_SEARCH;
								slot_q  <= 3'h0;
								dwell_q <= '0;
							end
						end
						CDR_SEARCH: begin
							if (!sig_q) begin
								state_q <= CDR_WAIT_SIGNAL;
							end else if (!slot_on) begin
								slot_q  <= slot_q + 3'h1;                     // skip
								dwell_q <= '0;
							end else if (lock_q) begin
								state_q <= CDR_ADAPT;
							end else if (dwell_q == TRY_CYCLES - 1'b1) begin
								slot_q  <= slot_q + 3'h1;
								dwell_q <= '0;
							end else begin
								dwell_q <= dwell_q + 1'b1;
							end
						end
						CDR_ADAPT: begin
							state_q <= CDR_LOCKED;
						end
						CDR_LOCKED: begin
							if (!sig_q || !lock_q) begin
								state_q <= CDR_WAIT_SIGNAL;                   // lost lock, search again
							end
						end
					endcase
				end
			end
		end

		// Outputs decoded from state, slot and adaptation mode registers
		assign cdr_held[c]     = (state_q == CDR_HELD);
		assign cdr_locked[c]   = (state_q == CDR_LOCKED);
		assign adapt_start[c]  = (state_q == CDR_ADAPT);
		assign adapt_mode[c]   = mem_q[ADDR_ADAPT[6:0]][ADAPT_MSB:ADAPT_LSB];
		assign trial_group[c]  = slot_q[0];
		assign trial_divide[c] = 4'h8 >> slot_q[2:1];

		// ------------------------------------------------------
		// Channel checks
		AST_BCAST_WRITE: assert property (@(posedge clock) disable iff (srst)
			wr_any && !wr_select && sel_q[SEL_CHAN] && sel_q[SEL_BCAST]
			&& mgmt_addr == ADDR_ADAPT
			|=> mem_q[ADDR_ADAPT[6:0]] == $past(mgmt_wdata))
			else $error("broadcast write missed a channel");
		AST_SHARED_NO_CH: assert property (@(posedge clock) disable iff (srst)
			wr_any && !sel_q[SEL_CHAN] && mgmt_addr == ADDR_ADAPT
			|=> $stable(mem_q[ADDR_ADAPT[6:0]]))
			else $error("shared write reached a channel set");
		AST_CH_RESET: assert property (@(posedge clock) disable iff (srst)
			ch_reset |=> mem_q[ADDR_DIVIDE[6:0]] == DIVIDE_RST
			&& !mem_q[ADDR_CH_RESET[6:0]][CH_RESET_BIT])
			else $error("channel restore incomplete");
		AST_OVR_HOLD: assert property (@(posedge clock) disable iff (srst)
			ce && override |=> state_q == CDR_HELD [*1] ##0 slot_q == 3'h0)
			else $error("override did not hold recovery");
		AST_RESTART: assert property (@(posedge clock) disable iff (srst)
			ce && state_q == CDR_HELD && !override |=> state_q == CDR_WAIT_SIGNAL)
			else $error("recovery did not restart");
		AST_ORDER: assert property (@(posedge clock) disable iff (srst)
			ce && !override && state_q == CDR_SEARCH && sig_q && !slot_on
			|=> slot_q == $past(slot_q) + 3'h1)
			else $error("search slot order broken");
		AST_DWELL_ENABLED: assert property (@(posedge clock) disable iff (srst)
			state_q == CDR_SEARCH && dwell_q != '0 |-> slot_on)
			else $error("dwelling on disabled ratio");
		COV_LOCKED: cover property (@(posedge clock) disable iff (srst)
			state_q == CDR_ADAPT ##1 state_q == CDR_LOCKED);
		COV_BCAST: cover property (@(posedge clock) disable iff (srst)
			wr_ch == 2'b11);
	end

	// ==========================================================
	// Shared checks
	AST_SH_RESET: assert property (@(posedge clock) disable iff (srst)
		sh_reset |=> sel_q == SELECT_RST && sh_q[ADDR_SH_RESET[2:0]] == 8'h00)
		else $error("shared restore incomplete");
	AST_REVISION: assert property (@(posedge clock) disable iff (srst)
		rd_any && !sel_q[SEL_CHAN] && mgmt_addr == ADDR_REVISION
		|=> mgmt_rdata == {REVISION_ID, VARIANT_ID} && mgmt_ack)
		else $error("revision read wrong");
	AST_SELECT_WR: assert property (@(posedge clock) disable iff (srst)
		wr_select |=> sel_q == $past(mgmt_wdata))
		else $error("select write lost");
	AST_CH_READ: assert property (@(posedge clock) disable iff (srst)
		rd_any && sel_q[SEL_CHAN] && sel_q[1:0] == 2'h1 && mgmt_addr != ADDR_SELECT
		|=> mgmt_rdata == $past(ch_rd[1]))
		else $error("channel read from wrong set");
	COV_SH_RESET: cover property (@(posedge clock) disable iff (srst) sh_reset);

endmodule : rts_select_reset

// [bench/rts_host_model.sv]
// Management host model issuing single-byte register accesses
module rts_host_model (
	// Clock
	input  wire logic       clock,
	// Request side
	output logic            mgmt_req,
	output logic            mgmt_we,
	output logic [7:0]      mgmt_addr,
	output logic [7:0]      mgmt_wdata,
	// Answer side
	input  wire logic [7:0] mgmt_rdata,
	input  wire logic       mgmt_ack
);
	timeunit 1ns;
	timeprecision 1ps;

	int n_lost = 0;  // Accesses whose ack missed its slot

	// ==========================================================
	// Idle bus at time zero
	initial begin
		mgmt_req   = 1'b0;
		mgmt_we    = 1'b0;
		mgmt_addr  = 8'h00;
		mgmt_wdata = 8'h00;
	end

	// ==========================================================
	// One-cycle strobe at a falling edge; ack is due one cycle on
	task automatic access(input logic we, input logic [7:0] a, input logic [7:0] d,
			output logic [7:0] q);
		@(negedge clock);
		mgmt_req   = 1'b1;
		mgmt_we    = we;
		mgmt_addr  = a;
		mgmt_wdata = d;
		@(negedge clock);
		// Released lines show the inverse so a stale value cannot pass
		mgmt_req   = 1'b0;
		mgmt_we    = ~we;
		mgmt_addr  = ~a;
		mgmt_wdata = ~d;
		if (mgmt_ack !== 1'b1)
			n_lost++;
		q = mgmt_rdata;
	endtask

	// Select writes always carry all eight intended bits
	task automatic sel(input logic [7:0] v);
		logic [7:0] q;
		access(1'b1, 8'hFF, v, q);
	endtask
endmodule // rts_host_model

// [bench/retimer_register_select_and_reset_tb_top.sv]
// Self-checking bench for the register select and reset block
module retimer_register_select_and_reset_tb_top
	import rts_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// Signals
	logic             clock = 1'b0;
	logic             srst  = 1'b1;
	logic             mgmt_req, mgmt_we, mgmt_ack;
	logic [7:0]       mgmt_addr, mgmt_wdata, mgmt_rdata;
	logic [1:0]       signal_detect = 2'b11;  // Input present on both channels
	logic [1:0]       phase_lock    = 2'b00;  // No lock until asked for
	logic [1:0]       cdr_held, cdr_locked, adapt_start, trial_group;
	logic [1:0][1:0]  adapt_mode;
	logic [1:0][3:0]  trial_divide;
	logic [7:0]       a, da, db;
	logic             seen;
	int               n_errors = 0;
	int               n_checks = 0;
	int               cycles   = 0;
	int               seed     = 32'h6F7983B7;
	// Enabled divide ratios per rate/subrate, group 1 in the high nibble
	localparam logic [7:0] EXP_EN [16] = '{8'h18, 8'h17, 8'h77, 8'h77, 8'h66, 8'h55,
		8'hFF, 8'h11, 8'h11, 8'h11, 8'h22, 8'h66, 8'h11, 8'h11, 8'h11, 8'h18};

	// ==========================================================
	// Clock and instances
	always #12.5 clock = ~clock;

	rts_select_reset i_rts_select_reset (
		.clock(clock), .srst(srst), .ce(1'b1), .mgmt_req(mgmt_req), .mgmt_we(mgmt_we),
		.mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
		.mgmt_ack(mgmt_ack), .signal_detect(signal_detect), .phase_lock(phase_lock),
		.cdr_held(cdr_held), .cdr_locked(cdr_locked), .adapt_start(adapt_start),
		.adapt_mode(adapt_mode), .trial_group(trial_group), .trial_divide(trial_divide));

	rts_host_model i_rts_host_model (
		.clock(clock), .mgmt_req(mgmt_req), .mgmt_we(mgmt_we), .mgmt_addr(mgmt_addr),
		.mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata), .mgmt_ack(mgmt_ack));

	// ==========================================================
	// Helpers
	task automatic final_report();
		if (n_errors == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		logic [7:0] q;
		i_rts_host_model.access(1'b1, ad, d, q);
	endtask

	task automatic rdc(input string n, input logic [7:0] ad, input logic [7:0] e);
		logic [7:0] q;
		i_rts_host_model.access(1'b0, ad, 8'h00, q);
		chk(n, e, q);
	endtask

	task automatic sel(input logic [7:0] v);
		i_rts_host_model.sel(v);
	endtask

	// Hold, program a ratio set, release, then log channel A's dwell slots
	task automatic sweep(input logic [3:0] rs);
		logic [4:0] key, prev;
		logic [7:0] m, mask;
		logic [3:0] last;
		logic       bad;
		int         run;
		mask = 8'h00;
		last = 4'hF;
		bad  = 1'b0;
		run  = 0;
		prev = 5'h00;
		sel(8'h0C);
		wr(ADDR_OVERRIDE, 8'h04);
		@(negedge clock);
		chk("half_override", 8'h00, {6'h00, cdr_held});
		wr(ADDR_OVERRIDE, 8'h0C);
		@(negedge clock);
		chk("held", 8'h03, {6'h00, cdr_held});
		wr(ADDR_DIVIDE, {rs, 4'h0});
		rdc("divide_kept", ADDR_DIVIDE, {rs, 4'h0});
		wr(ADDR_OVERRIDE, 8'h00);
		for (int c = 0; c < 420; c++) begin
			@(negedge clock);
			key  = {trial_group[0], trial_divide[0]};
			run  = (key == prev) ? run + 1 : 1;
			prev = key;
			// Only enabled slots dwell long; skipped ones last a cycle
			if (run == 20) begin
				m = trial_group[0] ? {trial_divide[0], 4'h0} : {4'h0, trial_divide[0]};
				if ((mask & m) != 8'h00)
					break;
				if (trial_divide[0] > last)
					bad = 1'b1;
				last = trial_divide[0];
				mask = mask | m;
			end
		end
		chk("ratio_mask", EXP_EN[rs], mask);
		chk("search_order", 8'h00, {7'h00, bad});
	endtask

	// ==========================================================
	// Hang guard
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			final_report();
		end
	end

	// ==========================================================
	// Main sequence
	initial begin
		repeat (3) @(negedge clock);
		srst = 1'b0;
		rdc("select_rst", ADDR_SELECT, 8'h00);
		rdc("revision", ADDR_REVISION, {REVISION_ID, VARIANT_ID});
		wr(ADDR_REVISION, 8'hAA);
		rdc("revision_ro", ADDR_REVISION, {REVISION_ID, VARIANT_ID});
		sel(8'h04);
		rdc("divide_default", ADDR_DIVIDE, 8'h60);
		rdc("select_chan", ADDR_SELECT, 8'h04);
		// Random traffic to each channel separately
		for (int i = 0; i < 8; i++) begin
			a  = 8'h40 | 8'($random(seed) & 31);
			da = 8'($random(seed));
			db = 8'($random(seed));
			sel(8'h04);
			wr(a, da);
			sel(8'h05);
			wr(a, db);
			rdc("chan_b", a, db);
			sel(8'h04);
			rdc("chan_a", a, da);
		end
		// Broadcast write, reads from either channel
		da = 8'($random(seed));
		sel(8'h0C);
		wr(ADDR_ADAPT, da);
		rdc("bcast_a", ADDR_ADAPT, da);
		sel(8'h0D);
		rdc("bcast_b", ADDR_ADAPT, da);
		chk("adapt_mode", {4'h0, da[6:5], da[6:5]}, {4'h0, adapt_mode});
		// Channel soft reset touches only channel A
		sel(8'h04);
		wr(ADDR_FCOUNT_0, 8'h55);
		sel(8'h05);
		wr(ADDR_FCOUNT_0, 8'h33);
		sel(8'h04);
		wr(ADDR_CH_RESET, 8'h04);
		rdc("ch_reset_bit", ADDR_CH_RESET, 8'h00);
		rdc("fcount_a", ADDR_FCOUNT_0, FCOUNT_0_RST);
		rdc("adapt_a", ADDR_ADAPT, 8'h00);
		sel(8'h05);
		rdc("fcount_b", ADDR_FCOUNT_0, 8'h33);
		// Shared soft reset, select left at a shared-mode value
		sel(8'h08);
		wr(8'h07, da);
		rdc("shared_rw", 8'h07, da);
		wr(ADDR_SH_RESET, 8'h40);
		rdc("sh_reset_bit", ADDR_SH_RESET, 8'h00);
		rdc("shared_rst", 8'h07, 8'h00);
		rdc("select_rst2", ADDR_SELECT, 8'h00);
		// Every rate/subrate combination
		for (int r = 0; r < 16; r++)
			sweep(4'(r));
		// Lock while searching
		phase_lock = 2'b01;
		seen = 1'b0;
		for (int c = 0; c < 100 && cdr_locked[0] !== 1'b1; c++) begin
			@(negedge clock);
			seen = seen | adapt_start[0];
		end
		chk("adapt_start", 8'h01, {7'h00, seen});
		chk("locked", 8'h01, {7'h00, cdr_locked[0]});
		chk("lost_acks", 8'h00, 8'(i_rts_host_model.n_lost));
		final_report();
	end
endmodule // retimer_register_select_and_reset_tb_top
